// ===== shp_pkg.sv
// shared constants, types and helpers for the host bus port
package shp_pkg;

	// ----------------------------------------
	// widths
	// ----------------------------------------
	localparam int DW = 32;
	localparam int HW = 16;

	// ----------------------------------------
	// host address map (byte addresses)
	// ----------------------------------------
	localparam logic [1:0] FIFO_REGION = 2'h0;
	localparam int RXTX_BIT = 5;
	localparam logic [2:0] MAC_REGION = 3'h5;
	localparam int CSR_IDX_LSB = 2;
	localparam int CSR_IDX_W = 6;

	// ----------------------------------------
	// buffer depths as address widths
	// ----------------------------------------
	localparam int TXB_AW = 9;
	localparam int RXB_AW = 5;
	localparam int SKID_AW = 1;

	// ----------------------------------------
	// timing
	// ----------------------------------------
	localparam int CLK_PERIOD_PS = 5000;
	localparam int IRQ_GAP_UNIT_US = 10;
	localparam int IRQ_GAP_UNIT_CYC = (IRQ_GAP_UNIT_US * 1000000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
	localparam int IRQ_GAP_W = 8;

	// ----------------------------------------
	// reset values
	// ----------------------------------------
	localparam logic [DW-1:0] DATA_RST = 32'h0000_0000;

	// ----------------------------------------
	// types
	// ----------------------------------------
	typedef struct packed
	{
		logic we;
		logic [CSR_IDX_W-1:0] idx;
		logic [DW-1:0] wdata;
	} shp_csr_req_t;

	typedef struct packed
	{
		logic last;
		logic [DW-1:0] data;
	} shp_frame_word_t;

	typedef enum logic [1:0]
	{
		TGT_RXF,
		TGT_TXF,
		TGT_MAC,
		TGT_CSR
	} shp_target_t;

	// ----------------------------------------
	// byte reversal of one word
	// ----------------------------------------
	function automatic logic [DW-1:0] shp_swap32(input logic [DW-1:0] w);
		shp_swap32 = {w[7:0], w[15:8], w[23:16], w[31:24]};
	endfunction : shp_swap32

endpackage : shp_pkg

// ===== shp_buf.sv
// small memory buffer with registered read data and valid/ready on both sides
`timescale 1ns/10ps
module shp_buf #(
	parameter int W = 32,
	parameter int AW = 1
) (
	// clock and reset
	input wire logic clock_i,
	input wire logic rst_b_i,
	// fill side
	input wire logic in_valid_i,
	input wire logic [W-1:0] in_data_i,
	output logic in_ready_o,
	// drain side
	output logic out_valid_o,
	output logic [W-1:0] out_data_o,
	input wire logic out_ready_i
);
	localparam int DEPTH = 1 << AW;

	logic [W-1:0] mem [DEPTH];
	logic [AW-1:0] wr_q;
	logic [AW-1:0] rd_q;
	logic [AW:0] cnt_q;
	logic [W-1:0] out_q;
	logic out_valid_q;

	wire logic push = in_valid_i & in_ready_o;
	wire logic load = (cnt_q != '0) & (~out_valid_q | out_ready_i);
	wire logic [AW:0] fill = cnt_q + (AW+1)'(out_valid_q);
	assign in_ready_o = (fill != (AW+1)'(DEPTH)) | (out_valid_q & out_ready_i);
	assign out_valid_o = out_valid_q;
	assign out_data_o = out_q;

	always_ff @(posedge clock_i)
	begin
		if (push)
			mem[wr_q] <= in_data_i;
		if (load)
			out_q <= mem[rd_q];
	end

	always_ff @(posedge clock_i or negedge rst_b_i)
	begin
		if (!rst_b_i)
		begin
			wr_q <= '0;
			rd_q <= '0;
			cnt_q <= '0;
			out_valid_q <= 1'b0;
		end
		else
		begin
			wr_q <= wr_q + AW'(push);
			rd_q <= rd_q + AW'(load);
			cnt_q <= cnt_q + (AW+1)'(push) - (AW+1)'(load);
			if (load)
				out_valid_q <= 1'b1;
			else if (out_ready_i)
				out_valid_q <= 1'b0;
		end
	end
endmodule : shp_buf

// ===== shp_port.sv
// host bus port with data buffering, interrupt pin and mac interface layer
// ----------------------------------------
// Summary of operation
// - host transfers 32 or 16 bits wide; internal words always 32 bits
// - seven-bit word address picks registers, transmit fifo or receive fifo
// - low read strobe means a read request
// - low write strobe with read strobe high means a write request
// - strobes count only while chip select is low
// - qualified write in low power raises a wakeup request
// - fifo select high sends every access to the data fifos, upper address ignored
// - byte order select low is little endian, high big endian
// - byte order sampled with the read or write strobe, host times it like address
// - byte order input has an internal pull-down, little endian if open
// - upper data line pull-downs off in 32-bit mode
// - fifo traffic may use a byte order different from register traffic
// - interrupt pin polarity and push-pull or open-drain type selectable
// - interrupt held deasserted for a programmable interval after it drops
// - mac layer owns 2 kbyte transmit and 128 byte receive buffers, host unreachable
// - transmit frame fully buffered before sending starts
// - received data moves to the host receive fifo before host reads it
// - mac registers sit on their own internal bus reached through this port
// - bus width strap caught at reset release, high 32-bit, low 16-bit
// ----------------------------------------
`timescale 1ns/10ps
module shp_port #(
	parameter int GAP_UNIT_CYC = shp_pkg::IRQ_GAP_UNIT_CYC
) (
	// clock and reset
	input wire logic clock_i,
	input wire logic rst_b_i,
	// host pins
	input wire logic chip_select_n_i,
	input wire logic read_strobe_n_i,
	input wire logic write_strobe_n_i,
	input wire logic [7:1] addr_i,
	input wire logic fifo_sel_i,
	input wire logic byte_order_sel_i,
	input wire logic [31:0] data_i,
	output logic [31:0] data_o,
	output logic data_oe_o,
	output logic irq_o,
	output logic irq_oe_o,
	// straps and pad control
	input wire logic bus_width_strap_i,
	output logic bus_wide_o,
	output logic data_hi_pd_en_o,
	output logic byte_order_pd_en_o,
	// configuration and status
	input wire logic fifo_swap_i,
	input wire logic irq_src_i,
	input wire logic irq_pol_i,
	input wire logic irq_od_i,
	input wire logic [7:0] irq_gap_i,
	input wire logic low_power_i,
	output logic wakeup_o,
	// internal register bus
	output logic csr_valid_o,
	output shp_pkg::shp_csr_req_t csr_req_o,
	input wire logic [31:0] csr_rdata_i,
	// mac register bus
	output logic mac_csr_valid_o,
	output shp_pkg::shp_csr_req_t mac_csr_req_o,
	input wire logic [31:0] mac_csr_rdata_i,
	// host data fifos
	input wire logic [31:0] rxf_data_i,
	output logic rxf_pop_o,
	output logic txf_valid_o,
	output logic [31:0] txf_data_o,
	input wire logic txf_ready_i,
	output logic txf_space_o,
	// mac interface layer, transmit
	input wire logic mil_tx_valid_i,
	input wire shp_pkg::shp_frame_word_t mil_tx_word_i,
	output logic mil_tx_ready_o,
	output logic mac_tx_valid_o,
	output shp_pkg::shp_frame_word_t mac_tx_word_o,
	input wire logic mac_tx_ready_i,
	// mac interface layer, receive
	input wire logic mac_rx_valid_i,
	input wire logic [31:0] mac_rx_data_i,
	output logic mac_rx_ready_o,
	output logic rxf_fill_valid_o,
	output logic [31:0] rxf_fill_data_o,
	input wire logic rxf_fill_ready_i
);
	// ----------------------------------------
	// strap capture and pad control
	// ----------------------------------------
	logic wide_q;
	logic strap_done_q;

	always_ff @(posedge clock_i or negedge rst_b_i)
	begin
		if (!rst_b_i)
		begin
			wide_q <= 1'b0;
			strap_done_q <= 1'b0;
		end
		else if (!strap_done_q)
		begin
			wide_q <= bus_width_strap_i;
			strap_done_q <= 1'b1;
		end
	end

	assign bus_wide_o = wide_q;
	assign data_hi_pd_en_o = ~wide_q;
	assign byte_order_pd_en_o = 1'b1;

	// ----------------------------------------
	// strobe qualification and decode
	// ----------------------------------------
	logic act_q;
	logic [15:0] half_q;
	logic [31:0] rd_hold_q;
	logic [31:0] data_q;
	logic oe_q;
	logic wake_q;

	wire logic sel = ~chip_select_n_i;
	wire logic rd_req = sel & ~read_strobe_n_i;
	wire logic wr_req = sel & ~write_strobe_n_i & read_strobe_n_i;
	wire logic act = rd_req | wr_req;
	wire logic start = act & ~act_q;
	wire logic [7:0] baddr = {addr_i, 1'b0};
	wire logic upper = addr_i[1];
	wire logic fifo_hit = fifo_sel_i | (baddr[7:6] == shp_pkg::FIFO_REGION);
	wire logic mac_hit = ~fifo_sel_i & (baddr[7:5] == shp_pkg::MAC_REGION);
	wire shp_pkg::shp_target_t tgt = fifo_hit ? ((fifo_sel_i ? wr_req : baddr[shp_pkg::RXTX_BIT])
		? shp_pkg::TGT_TXF : shp_pkg::TGT_RXF) : (mac_hit ? shp_pkg::TGT_MAC : shp_pkg::TGT_CSR);
	wire logic big = fifo_hit ? (byte_order_sel_i ^ fifo_swap_i) : byte_order_sel_i;
	wire logic whole = wide_q | upper;
	wire logic fetch = start & rd_req & (wide_q | ~upper);

	// ----------------------------------------
	// write word assembly and read word selection
	// ----------------------------------------
	wire logic [31:0] wr_raw = wide_q ? data_i : {data_i[15:0], half_q};
	wire logic [31:0] wr_word = big ? shp_pkg::shp_swap32(wr_raw) : wr_raw;
	wire logic commit = start & wr_req & whole;
	wire logic [31:0] rd_src = (tgt == shp_pkg::TGT_RXF) ? rxf_data_i
		: ((tgt == shp_pkg::TGT_MAC) ? mac_csr_rdata_i : csr_rdata_i);
	wire logic [31:0] rd_word = big ? shp_pkg::shp_swap32(rd_src) : rd_src;
	wire logic [31:0] rd_next = wide_q ? rd_word
		: {16'h0000, upper ? rd_hold_q[31:16] : rd_word[15:0]};

	wire shp_pkg::shp_csr_req_t req = '{we: wr_req, idx: baddr[shp_pkg::CSR_IDX_LSB +: shp_pkg::CSR_IDX_W],
		wdata: wr_word};
	assign csr_req_o = req;
	assign mac_csr_req_o = req;
	assign csr_valid_o = (tgt == shp_pkg::TGT_CSR) & (commit | fetch);
	assign mac_csr_valid_o = (tgt == shp_pkg::TGT_MAC) & (commit | fetch);
	assign rxf_pop_o = start & rd_req & whole & (tgt == shp_pkg::TGT_RXF);

	always_ff @(posedge clock_i or negedge rst_b_i)
	begin
		if (!rst_b_i)
		begin
			act_q <= 1'b0;
			half_q <= 16'h0000;
			rd_hold_q <= shp_pkg::DATA_RST;
			data_q <= shp_pkg::DATA_RST;
			oe_q <= 1'b0;
			wake_q <= 1'b0;
		end
		else
		begin
			act_q <= act;
			oe_q <= rd_req;
			wake_q <= low_power_i & sel & ~write_strobe_n_i & ~act_q;
			if (start & wr_req & ~whole)
				half_q <= data_i[15:0];
			if (fetch)
				rd_hold_q <= rd_word;
			if (start & rd_req)
				data_q <= rd_next;
		end
	end

	assign data_o = data_q;
	assign data_oe_o = oe_q;
	assign wakeup_o = wake_q;

	// ----------------------------------------
	// two-entry buffer toward host transmit fifo
	// ----------------------------------------
	shp_buf #(.W(32), .AW(shp_pkg::SKID_AW)) u_skid (
		.clock_i(clock_i),
		.rst_b_i(rst_b_i),
		.in_valid_i(commit & (tgt == shp_pkg::TGT_TXF)),
		.in_data_i(wr_word),
		.in_ready_o(txf_space_o),
		.out_valid_o(txf_valid_o),
		.out_data_o(txf_data_o),
		.out_ready_i(txf_ready_i)
	);

	// ----------------------------------------
	// interrupt pin with deassertion interval
	// ----------------------------------------
	logic irq_q;
	logic [7:0] gap_q;
	logic [31:0] unit_q;

	wire logic gap_busy = (gap_q != 8'h00);
	wire logic irq_d = irq_src_i & ~gap_busy;
	wire logic irq_fall = irq_q & ~irq_d;

	always_ff @(posedge clock_i or negedge rst_b_i)
	begin
		if (!rst_b_i)
		begin
			irq_q <= 1'b0;
			gap_q <= 8'h00;
			unit_q <= 32'h0000_0000;
		end
		else
		begin
			irq_q <= irq_d;
			if (irq_fall)
			begin
				gap_q <= irq_gap_i;
				unit_q <= 32'(GAP_UNIT_CYC - 1);
			end
			else if (gap_busy)
			begin
				if (unit_q == 32'h0000_0000)
				begin
					gap_q <= gap_q - 8'h01;
					unit_q <= 32'(GAP_UNIT_CYC - 1);
				end
				else
					unit_q <= unit_q - 32'h0000_0001;
			end
		end
	end

	assign irq_o = irq_od_i ? irq_pol_i : (irq_q ~^ irq_pol_i);
	assign irq_oe_o = irq_od_i ? irq_q : 1'b1;

	// ----------------------------------------
	// mac interface layer transmit, store and forward
	// ----------------------------------------
	logic [7:0] frames_q;
	logic txb_valid;
	shp_pkg::shp_frame_word_t txb_word;

	wire logic tx_in = mil_tx_valid_i & mil_tx_ready_o;
	wire logic tx_out = txb_valid & mac_tx_ready_i & (frames_q != 8'h00);
	wire logic frame_in = tx_in & mil_tx_word_i.last;
	wire logic frame_out = tx_out & txb_word.last;

	shp_buf #(.W(33), .AW(shp_pkg::TXB_AW)) u_txb (
		.clock_i(clock_i),
		.rst_b_i(rst_b_i),
		.in_valid_i(mil_tx_valid_i),
		.in_data_i(mil_tx_word_i),
		.in_ready_o(mil_tx_ready_o),
		.out_valid_o(txb_valid),
		.out_data_o(txb_word),
		.out_ready_i(mac_tx_ready_i & (frames_q != 8'h00))
	);

	always_ff @(posedge clock_i or negedge rst_b_i)
	begin
		if (!rst_b_i)
			frames_q <= 8'h00;
		else
			frames_q <= frames_q + 8'(frame_in) - 8'(frame_out);
	end

	assign mac_tx_valid_o = txb_valid & (frames_q != 8'h00);
	assign mac_tx_word_o = txb_word;

	// ----------------------------------------
	// mac interface layer receive
	// ----------------------------------------
	shp_buf #(.W(32), .AW(shp_pkg::RXB_AW)) u_rxb (
		.clock_i(clock_i),
		.rst_b_i(rst_b_i),
		.in_valid_i(mac_rx_valid_i),
		.in_data_i(mac_rx_data_i),
		.in_ready_o(mac_rx_ready_o),
		.out_valid_o(rxf_fill_valid_o),
		.out_data_o(rxf_fill_data_o),
		.out_ready_i(rxf_fill_ready_i)
	);

	// ----------------------------------------
	// checks
	// ----------------------------------------
	chk_cs_gates_access: assert property (@(posedge clock_i) disable iff (!rst_b_i)
		chip_select_n_i |-> !(csr_valid_o || mac_csr_valid_o || rxf_pop_o))
		else $error("access taken without chip select");

	chk_read_drives_bus: assert property (@(posedge clock_i) disable iff (!rst_b_i)
		(!chip_select_n_i && !read_strobe_n_i) |=> data_oe_o)
		else $error("read strobe did not enable data drive");

	chk_write_no_drive: assert property (@(posedge clock_i) disable iff (!rst_b_i)
		(!chip_select_n_i && !write_strobe_n_i && read_strobe_n_i) |=> !data_oe_o)
		else $error("data driven during write");

	chk_wakeup_on_write: assert property (@(posedge clock_i) disable iff (!rst_b_i)
		(low_power_i && !chip_select_n_i && !write_strobe_n_i && !act_q) |=> wakeup_o)
		else $error("no wakeup on qualified write");

	chk_fifo_sel_route: assert property (@(posedge clock_i) disable iff (!rst_b_i)
		(fifo_sel_i && commit && txf_space_o) |-> ##2 txf_valid_o)
		else $error("fifo select write did not reach transmit fifo");

	chk_pulldown_width: assert property (@(posedge clock_i) disable iff (!rst_b_i)
		strap_done_q |-> (data_hi_pd_en_o == !bus_wide_o))
		else $error("upper pull-down state wrong for bus width");

	chk_strap_hold: assert property (@(posedge clock_i) disable iff (!rst_b_i)
		strap_done_q |=> $stable(bus_wide_o))
		else $error("bus width changed after capture");

	chk_strap_capture: assert property (@(posedge clock_i) disable iff (!rst_b_i)
		$rose(strap_done_q) |-> (bus_wide_o == $past(bus_width_strap_i)))
		else $error("bus width not taken from strap");

	chk_irq_gap_hold: assert property (@(posedge clock_i) disable iff (!rst_b_i)
		($fell(irq_q) && $past(irq_gap_i) != 8'h00) |-> !irq_q [*4])
		else $error("interrupt reasserted inside hold interval");

	chk_tx_whole_frame: assert property (@(posedge clock_i) disable iff (!rst_b_i)
		mac_tx_valid_o |-> (frames_q != 8'h00))
		else $error("transmit started before frame complete");

	chk_narrow_upper_zero: assert property (@(posedge clock_i) disable iff (!rst_b_i)
		(strap_done_q && !wide_q && data_oe_o) |-> (data_o[31:16] == 16'h0000))
		else $error("upper data lines carry data in 16-bit mode");

endmodule : shp_port

// ===== shp_csr_model.sv
// register responder behind the internal register buses
`timescale 1ns/10ps
module shp_csr_model (
	// clock and reset
	input wire logic clock_i,
	input wire logic rst_b_i,
	// register bus
	input wire logic valid_i,
	input wire shp_pkg::shp_csr_req_t req_i,
	output logic [31:0] rdata_o,
	output logic [7:0] n_wr_o
);
	// ----------------------------------------
	// storage and answer
	// ----------------------------------------
	logic [31:0] mem_q [64];
	logic [7:0] n_wr_q;
	// idle bus shows the inverted word
	assign rdata_o = valid_i ? mem_q[req_i.idx] : ~mem_q[req_i.idx];
	assign n_wr_o = n_wr_q;
	always_ff @(posedge clock_i or negedge rst_b_i)
	begin
		if (!rst_b_i)
			n_wr_q <= 8'h00;
		else if (valid_i && req_i.we)
		begin
			mem_q[req_i.idx] <= req_i.wdata;
			n_wr_q <= n_wr_q + 8'h01;
		end
	end
endmodule : shp_csr_model

// ===== sram_like_host_bus_port_tb.sv
// self-checking bench for the host bus port
`timescale 1ns/10ps
module sram_like_host_bus_port_tb;
	`define CHK(a, b) begin checked++; if ((a) !== (b)) begin n_fail++; \
		$display("MISMATCH t=%0t got=%h exp=%h", $time, (a), (b)); end end
	// ----------------------------------------
	// signals
	// ----------------------------------------
	logic clock_i, rst_b_i, chip_select_n_i, read_strobe_n_i, write_strobe_n_i, fifo_sel_i, byte_order_sel_i;
	logic [7:1] addr_i;
	logic [31:0] data_i, data_o, csr_rdata_i, mac_csr_rdata_i, rxf_data_i, txf_data_o, mac_rx_data_i;
	logic [31:0] rxf_fill_data_o;
	logic data_oe_o, irq_o, irq_oe_o, bus_width_strap_i, bus_wide_o, data_hi_pd_en_o, byte_order_pd_en_o;
	logic fifo_swap_i, irq_src_i, irq_pol_i, irq_od_i, low_power_i, wakeup_o, csr_valid_o, mac_csr_valid_o;
	logic [7:0] irq_gap_i, n_csr, n_mac;
	logic rxf_pop_o, txf_valid_o, txf_ready_i, txf_space_o, mil_tx_valid_i, mil_tx_ready_o, mac_tx_valid_o;
	logic mac_tx_ready_i, mac_rx_valid_i, mac_rx_ready_o, rxf_fill_valid_o, rxf_fill_ready_i;
	shp_pkg::shp_csr_req_t csr_req_o, mac_csr_req_o;
	shp_pkg::shp_frame_word_t mil_tx_word_i, mac_tx_word_o;
	int n_fail = 0, checked = 0, n_wake = 0, n_pop = 0, i, n;
	logic [31:0] r, got [4];
	// ----------------------------------------
	// instances
	// ----------------------------------------
	shp_port #(.GAP_UNIT_CYC(4)) shp_port_i (.clock_i, .rst_b_i, .chip_select_n_i, .read_strobe_n_i,
		.write_strobe_n_i, .addr_i, .fifo_sel_i, .byte_order_sel_i, .data_i, .data_o, .data_oe_o, .irq_o,
		.irq_oe_o, .bus_width_strap_i, .bus_wide_o, .data_hi_pd_en_o, .byte_order_pd_en_o, .fifo_swap_i,
		.irq_src_i, .irq_pol_i, .irq_od_i, .irq_gap_i, .low_power_i, .wakeup_o, .csr_valid_o, .csr_req_o,
		.csr_rdata_i, .mac_csr_valid_o, .mac_csr_req_o, .mac_csr_rdata_i, .rxf_data_i, .rxf_pop_o,
		.txf_valid_o, .txf_data_o, .txf_ready_i, .txf_space_o, .mil_tx_valid_i, .mil_tx_word_i,
		.mil_tx_ready_o, .mac_tx_valid_o, .mac_tx_word_o, .mac_tx_ready_i, .mac_rx_valid_i, .mac_rx_data_i,
		.mac_rx_ready_o, .rxf_fill_valid_o, .rxf_fill_data_o, .rxf_fill_ready_i);
	shp_csr_model shp_csr_model_i (.clock_i, .rst_b_i, .valid_i(csr_valid_o), .req_i(csr_req_o),
		.rdata_o(csr_rdata_i), .n_wr_o(n_csr));
	shp_csr_model mac_model_i (.clock_i, .rst_b_i, .valid_i(mac_csr_valid_o), .req_i(mac_csr_req_o),
		.rdata_o(mac_csr_rdata_i), .n_wr_o(n_mac));
	initial
	begin
		clock_i = 1'b0;
		forever #2.5 clock_i = ~clock_i;
	end
	always @(posedge clock_i)
		if (wakeup_o === 1'b1)
			n_wake++;
	always @(posedge clock_i)
		if (rxf_pop_o === 1'b1)
			n_pop++;
	// ----------------------------------------
	// helpers
	// ----------------------------------------
	function automatic logic [31:0] rev(input logic [31:0] w);
		rev = {w[7:0], w[15:8], w[23:16], w[31:24]};
	endfunction : rev
	task automatic print_verdict();
		$display("comparisons %0d mismatches %0d", checked, n_fail);
		if (n_fail == 0 && checked > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask : print_verdict
	// one host cycle, strobe held over two edges
	task automatic acc(input logic we, input logic cs, input logic [7:1] a, input logic [31:0] d,
		input logic fs, input logic bo, output logic [31:0] q);
		@(posedge clock_i);
		chip_select_n_i <= cs;
		write_strobe_n_i <= !we;
		read_strobe_n_i <= we;
		addr_i <= a;
		data_i <= d;
		fifo_sel_i <= fs;
		byte_order_sel_i <= bo;
		repeat (2) @(posedge clock_i);
		chip_select_n_i <= 1'b1;
		read_strobe_n_i <= 1'b1;
		write_strobe_n_i <= 1'b1;
		data_i <= ~d;
		#1 q = data_o;
	endtask : acc
	task automatic push_tx(input logic l, input logic [31:0] d);
		@(posedge clock_i);
		mil_tx_valid_i <= 1'b1;
		mil_tx_word_i <= '{last: l, data: d};
		for (i = 0; i < 20 && mil_tx_ready_o !== 1'b1; i++) @(negedge clock_i);
		@(posedge clock_i);
		mil_tx_valid_i <= 1'b0;
		if (i == 20)
		begin
			n_fail++;
			print_verdict();
		end
	endtask : push_tx
	// ----------------------------------------
	// scenarios
	// ----------------------------------------
	task automatic t_strap();
		`CHK(bus_wide_o, 1'b1)
		`CHK(data_hi_pd_en_o, 1'b0)
		`CHK(byte_order_pd_en_o, 1'b1)
		$display("t_strap done");
	endtask : t_strap
	task automatic t_csr();
		fifo_swap_i <= 1'b1;
		acc(1, 0, 7'h2a, 32'h1122_3344, 0, 0, r);
		`CHK(data_oe_o, 1'b0)
		acc(0, 0, 7'h2a, 32'h0, 0, 0, r);
		`CHK(data_oe_o, 1'b1)
		`CHK(r, 32'h1122_3344)
		acc(0, 0, 7'h2a, 32'h0, 0, 1, r);
		`CHK(r, rev(32'h1122_3344))
		acc(1, 0, 7'h2c, 32'haabb_ccdd, 0, 1, r);
		acc(0, 0, 7'h2c, 32'h0, 0, 0, r);
		`CHK(r, rev(32'haabb_ccdd))
		acc(1, 0, 7'h52, 32'h5566_7788, 0, 0, r);
		`CHK(n_mac, 8'h01)
		`CHK(n_csr, 8'h02)
		acc(0, 0, 7'h52, 32'h0, 0, 0, r);
		`CHK(r, 32'h5566_7788)
		acc(1, 1, 7'h2a, 32'hdead_beef, 0, 0, r);
		`CHK(n_csr, 8'h02)
		acc(0, 0, 7'h2a, 32'h0, 0, 0, r);
		`CHK(r, 32'h1122_3344)
		$display("t_csr done");
	endtask : t_csr
	task automatic t_fifo();
		fifo_swap_i <= 1'b0;
		acc(1, 0, 7'h7f, 32'h0102_0304, 1, 0, r);
		fifo_swap_i <= 1'b1;
		acc(1, 0, 7'h7f, 32'h0a0b_0c0d, 1, 0, r);
		repeat (3) @(posedge clock_i);
		`CHK(txf_space_o, 1'b0)
		acc(1, 0, 7'h7f, 32'h7777_7777, 1, 0, r);
		`CHK(n_csr, 8'h02)
		txf_ready_i <= 1'b1;
		n = 0;
		for (i = 0; i < 12; i++)
		begin
			@(negedge clock_i);
			if (txf_valid_o === 1'b1 && n < 4)
				got[n++] = txf_data_o;
		end
		`CHK(n, 2)
		`CHK(got[0], 32'h0102_0304)
		`CHK(got[1], rev(32'h0a0b_0c0d))
		fifo_swap_i <= 1'b0;
		acc(0, 0, 7'h55, 32'h0, 1, 0, r);
		`CHK(r, 32'h1234_5678)
		`CHK(n_pop, 1)
		$display("t_fifo done");
	endtask : t_fifo
	task automatic t_wake();
		low_power_i <= 1'b1;
		acc(1, 1, 7'h30, 32'h1, 0, 0, r);
		acc(0, 0, 7'h30, 32'h0, 0, 0, r);
		`CHK(n_wake, 0)
		acc(1, 0, 7'h30, 32'h1, 0, 0, r);
		`CHK(n_wake, 1)
		low_power_i <= 1'b0;
		acc(1, 0, 7'h30, 32'h1, 0, 0, r);
		`CHK(n_wake, 1)
		$display("t_wake done");
	endtask : t_wake
	task automatic t_irq();
		irq_src_i <= 1'b1;
		repeat (4) @(negedge clock_i);
		`CHK({irq_oe_o, irq_o}, 2'h3)
		@(posedge clock_i);
		irq_src_i <= 1'b0;
		@(posedge clock_i);
		irq_src_i <= 1'b1;
		repeat (3) @(negedge clock_i);
		`CHK(irq_o, 1'b0)
		repeat (6) @(negedge clock_i);
		`CHK(irq_o, 1'b0)
		@(negedge clock_i);
		`CHK(irq_o, 1'b1)
		irq_pol_i <= 1'b0;
		repeat (2) @(negedge clock_i);
		`CHK({irq_oe_o, irq_o}, 2'h2)
		irq_od_i <= 1'b1;
		irq_pol_i <= 1'b1;
		repeat (2) @(negedge clock_i);
		`CHK({irq_oe_o, irq_o}, 2'h3)
		irq_src_i <= 1'b0;
		repeat (2) @(negedge clock_i);
		`CHK({irq_oe_o, irq_o}, 2'h1)
		$display("t_irq done");
	endtask : t_irq
	task automatic t_mac();
		push_tx(0, 32'h0000_00a1);
		push_tx(0, 32'h0000_00a2);
		n = 0;
		for (i = 0; i < 8; i++) @(negedge clock_i) n += mac_tx_valid_o;
		`CHK(n, 0)
		push_tx(1, 32'h0000_00a3);
		n = 0;
		for (i = 0; i < 20; i++)
		begin
			@(negedge clock_i);
			if (mac_tx_valid_o === 1'b1 && n < 4)
				got[n++] = mac_tx_word_o.data;
		end
		`CHK(n, 3)
		`CHK(got[0], 32'h0000_00a1)
		@(posedge clock_i);
		mac_rx_valid_i <= 1'b1;
		mac_rx_data_i <= 32'hcafe_0001;
		for (i = 0; i < 20; i++)
		begin
			@(posedge clock_i);
			if (mac_rx_ready_o === 1'b1)
				break;
		end
		mac_rx_valid_i <= 1'b0;
		for (i = 0; i < 20 && rxf_fill_valid_o !== 1'b1; i++) @(negedge clock_i);
		`CHK(rxf_fill_valid_o, 1'b1)
		`CHK(rxf_fill_data_o, 32'hcafe_0001)
		$display("t_mac done");
	endtask : t_mac
	task automatic t_narrow();
		@(posedge clock_i);
		rst_b_i <= 1'b0;
		bus_width_strap_i <= 1'b0;
		repeat (3) @(posedge clock_i);
		rst_b_i <= 1'b1;
		repeat (2) @(posedge clock_i);
		`CHK({bus_wide_o, data_hi_pd_en_o}, 2'h1)
		acc(1, 0, 7'h2a, 32'h0000_beef, 0, 0, r);
		`CHK(n_csr, 8'h00)
		acc(1, 0, 7'h2b, 32'h0000_dead, 0, 0, r);
		`CHK(n_csr, 8'h01)
		acc(0, 0, 7'h2a, 32'h0, 0, 0, r);
		`CHK(r, 32'h0000_beef)
		acc(0, 0, 7'h2b, 32'h0, 0, 0, r);
		`CHK(r, 32'h0000_dead)
		acc(0, 0, 7'h2a, 32'h0, 0, 1, r);
		`CHK(r, 32'h0000_adde)
		acc(0, 0, 7'h2b, 32'h0, 0, 1, r);
		`CHK(r, 32'h0000_efbe)
		acc(0, 0, 7'h00, 32'h0, 0, 0, r);
		`CHK(r, 32'h0000_5678)
		`CHK(n_pop, 1)
		acc(0, 0, 7'h01, 32'h0, 0, 0, r);
		`CHK(r, 32'h0000_1234)
		`CHK(n_pop, 2)
		$display("t_narrow done");
	endtask : t_narrow
	// ----------------------------------------
	// main sequence
	// ----------------------------------------
	initial
	begin
		{rst_b_i, read_strobe_n_i, write_strobe_n_i, chip_select_n_i} = 4'h7;
		{fifo_sel_i, byte_order_sel_i, fifo_swap_i, irq_src_i, irq_od_i, low_power_i} = 6'h00;
		{txf_ready_i, mil_tx_valid_i, mac_rx_valid_i} = 3'h0;
		{irq_pol_i, mac_tx_ready_i, rxf_fill_ready_i, bus_width_strap_i} = 4'hf;
		addr_i = 7'h00;
		data_i = 32'h0;
		irq_gap_i = 8'h02;
		rxf_data_i = 32'h1234_5678;
		mac_rx_data_i = 32'h0;
		mil_tx_word_i = '0;
		repeat (10) @(posedge clock_i);
		rst_b_i <= 1'b1;
		repeat (2) @(posedge clock_i);
		t_strap();
		t_csr();
		t_fifo();
		t_wake();
		t_irq();
		t_mac();
		t_narrow();
		print_verdict();
	end
	initial
	begin
		#200000;
		n_fail++;
		print_verdict();
	end
endmodule : sram_like_host_bus_port_tb
